// ==== hdl/adc_conversion_sequencer.sv ====
`timescale 1ns/100ps
module adc_conversion_sequencer
	import adc_seq_pkg::*;
#(
	parameter int RES_W = RESULT_BITS
)
(
	input  wire logic             ref_clk_i,
	input  wire logic             resetn_i,
	input  wire logic [2:0]       addr_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic      [7:0]       rdata_o,
	input  wire logic             sleep_i,
	input  wire logic             instr_tick_i,
	input  wire logic             rc_tick_i,
	input  wire logic             comp_i,
	output logic                  powered_o,
	output logic                  hold_connect_o,
	output logic      [4:0]       chan_route_o,
	output logic                  chan_valid_o,
	output logic      [RES_W-1:0] dac_code_o,
	output logic                  irq_o,
	output logic                  wake_o,
	output logic                  vector_o
);
	// ====================================================================
	// Reset release
	// ====================================================================
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ====================================================================
	// Bus decode
	// ====================================================================
	bus_req_t bus;
	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	wire wr_ctrl_a = bus.wr && (bus.addr == ADDR_CTRL_A);
	wire wr_ctrl_b = bus.wr && (bus.addr == ADDR_CTRL_B);
	wire wr_flag   = bus.wr && (bus.addr == ADDR_FLAG);
	wire wr_irq_en = bus.wr && (bus.addr == ADDR_IRQ_EN);

	logic             enable_r;
	logic             go_r;
	logic [4:0]       chan_r;
	logic [2:0]       div_sel_r;
	logic             done_flag_r;
	logic [2:0]       irq_en_r;
	logic [RES_W-1:0] result_r;
	logic [RES_W-1:0] sar_r;
	logic [3:0]       period_r;
	logic             sleep_off_r;
	seq_state_t       state_r;
	seq_state_t       state_nxt;
	logic [7:0]       rdata_r;

	wire sw_go_set   = wr_ctrl_a && bus.wdata[CTRL_A_GO_BIT];
	wire sw_go_clr   = wr_ctrl_a && !bus.wdata[CTRL_A_GO_BIT];
	wire sw_enable   = bus.wdata[CTRL_A_ENABLE_BIT];

	// ====================================================================
	// Bit clock
	// ====================================================================
	logic tick;
	logic rc_sel;
	wire  running = (state_r != ST_IDLE);

	bit_clock_gen u_bit_clock (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_r),
		.run_i     (running),
		.div_sel_i (div_sel_r),
		.rc_tick_i (rc_tick_i),
		.tick_o    (tick),
		.rc_sel_o  (rc_sel)
	);

	// ====================================================================
	// Sequencer
	// ====================================================================
	// Sleep on a divided clock kills the conversion because that clock stops.
	wire sleep_abort = sleep_i && !rc_sel && (state_r == ST_CONVERT ||
	                   state_r == ST_RC_WAIT);
	wire sw_abort    = sw_go_clr && (state_r == ST_CONVERT ||
	                   state_r == ST_RC_WAIT);
	wire start_req   = sw_go_set && enable_r && sw_enable &&
	                   (state_r == ST_IDLE);
	wire last_period = (state_r == ST_CONVERT) && tick &&
	                   (period_r == CONV_PERIODS - 4'h1);
	wire finish      = last_period && !sleep_abort && !sw_abort;
	// The divider phase runs on across the abort, so the first tick may
	// come early; one extra tick is waited to give two whole periods.
	wire recov_done  = (state_r == ST_RECOVER) && tick &&
	                   (period_r == ABORT_PERIODS);
	wire [RES_W-1:0] final_code = sar_r | (comp_i ? {RES_W{1'b0}} :
	                   {RES_W{1'b0}});

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (start_req)
					state_nxt = rc_sel ? ST_RC_WAIT : ST_CONVERT;
			ST_RC_WAIT:
				if (sw_abort || sleep_abort)
					state_nxt = ST_RECOVER;
				else if (instr_tick_i)
					state_nxt = ST_CONVERT;
			ST_CONVERT:
				if (sw_abort || sleep_abort)
					state_nxt = ST_RECOVER;
				else if (finish)
					state_nxt = ST_IDLE;
			ST_RECOVER:
				if (recov_done)
					state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
		if (!enable_r)
			state_nxt = ST_IDLE;
	end

	// Successive approximation: the trial bit walks from the MSB down.
	wire [3:0]       bit_idx   = CONV_PERIODS - 4'h1 - period_r;
	wire             trial_ok  = (period_r != 4'h0) &&
	                             (bit_idx < 4'(RES_W));
	logic [RES_W-1:0] trial_mask;
	assign trial_mask = trial_ok ? (RES_W'(1) << bit_idx) : '0;
	wire [RES_W-1:0] sar_keep  = comp_i ? (sar_r | trial_mask) : sar_r;
	wire [RES_W-1:0] done_code = sar_keep;

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			state_r  <= ST_IDLE;
			period_r <= 4'h0;
			sar_r    <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				period_r <= 4'h0;
			else if (tick)
				period_r <= period_r + 4'h1;
			if (state_r != ST_CONVERT)
				sar_r <= '0;
			else if (tick)
				sar_r <= sar_keep;
		end
	end

	// ====================================================================
	// Software visible registers
	// ====================================================================
	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			enable_r    <= CTRL_A_RESET[CTRL_A_ENABLE_BIT];
			go_r        <= CTRL_A_RESET[CTRL_A_GO_BIT];
			chan_r      <= CTRL_A_RESET[CTRL_A_CHAN_LSB +: 5];
			div_sel_r   <= DIV_SEL_RESET;
			irq_en_r    <= 3'h0;
			done_flag_r <= 1'b0;
			result_r    <= '0;
			sleep_off_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl_a)
			begin
				enable_r <= sw_enable;
				chan_r   <= bus.wdata[CTRL_A_CHAN_LSB +: 5];
			end
			if (wr_ctrl_b)
				div_sel_r <= bus.wdata[CTRL_B_DIV_LSB +: 3];
			if (wr_irq_en)
				irq_en_r <= bus.wdata[2:0];
			// Go reads back as busy; finishing or aborting clears it.
			if (finish || sleep_abort || state_nxt == ST_IDLE)
				go_r <= 1'b0;
			if (start_req)
				go_r <= 1'b1;
			else if (sw_go_clr)
				go_r <= 1'b0;
			// Set beats a same-cycle software clear.
			if (finish)
				done_flag_r <= 1'b1;
			else if (wr_flag && !bus.wdata[0])
				done_flag_r <= 1'b0;
			if (finish)
				result_r <= done_code;
			if (sleep_abort || (finish && sleep_i && rc_sel &&
			    !irq_en_r[IRQ_EN_CONV_BIT]))
				sleep_off_r <= 1'b1;
			else if (!sleep_i || wr_ctrl_a)
				sleep_off_r <= 1'b0;
		end
	end

	// ====================================================================
	// Read port
	// ====================================================================
	wire [7:0] ctrl_a_rd = {1'b0, chan_r, go_r, enable_r};
	wire [7:0] res_hi_rd = {6'h00, result_r[RES_W-1:8]};
	wire [7:0] res_lo_rd = result_r[7:0];
	wire [7:0] rd_mux =
		(bus.addr == ADDR_CTRL_A)   ? ctrl_a_rd :
		(bus.addr == ADDR_CTRL_B)   ? {1'b0, div_sel_r, 4'h0} :
		(bus.addr == ADDR_RES_HIGH) ? res_hi_rd :
		(bus.addr == ADDR_RES_LOW)  ? res_lo_rd :
		(bus.addr == ADDR_FLAG)     ? {7'h00, done_flag_r} :
		(bus.addr == ADDR_IRQ_EN)   ? {5'h00, irq_en_r} :
		8'h00;

	always_ff @(posedge ref_clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
			rdata_r <= 8'h00;
		else
			rdata_r <= bus.rd ? rd_mux : 8'h00;
	end

	// ====================================================================
	// Outputs
	// ====================================================================
	wire chan_gap = (chan_r >= CHAN_GAP_LO && chan_r <= CHAN_GAP_HI) ||
	                (chan_r > CHAN_TOP);
	assign rdata_o        = rdata_r;
	assign powered_o      = enable_r && !sleep_off_r;
	assign chan_valid_o   = powered_o && !chan_gap;
	assign chan_route_o   = chan_r;
	// While powered, the holding cap tracks the input except while bits are resolved.
	assign hold_connect_o = powered_o && (state_r != ST_CONVERT);
	assign dac_code_o     = sar_r | trial_mask;
	assign irq_o          = done_flag_r && irq_en_r[IRQ_EN_CONV_BIT];
	assign wake_o         = irq_o && sleep_i;
	assign vector_o       = irq_o && irq_en_r[IRQ_EN_PERIPH_BIT] &&
	                        irq_en_r[IRQ_EN_GLOBAL_BIT];
	wire unused_ok = ^final_code;
endmodule : adc_conversion_sequencer

// ==== hdl/adc_seq_pkg.sv ====
package adc_seq_pkg;

	// ====================================================================
	// Register map (byte-wide registers, word index on the plain port)
	// ====================================================================
	localparam logic [2:0] ADDR_CTRL_A    = 3'h0;
	localparam logic [2:0] ADDR_CTRL_B    = 3'h1;
	localparam logic [2:0] ADDR_RES_HIGH  = 3'h2;
	localparam logic [2:0] ADDR_RES_LOW   = 3'h3;
	localparam logic [2:0] ADDR_FLAG      = 3'h4;
	localparam logic [2:0] ADDR_IRQ_EN    = 3'h5;

	// Field positions.
	localparam int CTRL_A_ENABLE_BIT  = 0;
	localparam int CTRL_A_GO_BIT      = 1;
	localparam int CTRL_A_CHAN_LSB    = 2;
	localparam int CTRL_B_DIV_LSB     = 4;
	localparam int IRQ_EN_CONV_BIT    = 0;
	localparam int IRQ_EN_PERIPH_BIT  = 1;
	localparam int IRQ_EN_GLOBAL_BIT  = 2;

	// Reset values.
	localparam logic [7:0] CTRL_A_RESET   = 8'h00;
	localparam logic [2:0] DIV_SEL_RESET  = 3'h0;

	// Divider select codes and divide ratios.
	localparam logic [2:0] DIV_SEL_8      = 3'h1;
	localparam logic [2:0] DIV_SEL_16     = 3'h5;
	localparam logic [2:0] DIV_SEL_32     = 3'h2;
	localparam logic [2:0] DIV_SEL_64     = 3'h6;
	localparam logic [1:0] DIV_SEL_RC_LOW = 2'h3;
	localparam logic [6:0] DIV_RATIO_8    = 7'h08;
	localparam logic [6:0] DIV_RATIO_16   = 7'h10;
	localparam logic [6:0] DIV_RATIO_32   = 7'h20;
	localparam logic [6:0] DIV_RATIO_64   = 7'h40;

	// Sequencing counts, in bit clock periods, and the result width in bits.
	localparam logic [3:0] CONV_PERIODS   = 4'hb;
	localparam logic [3:0] ABORT_PERIODS  = 4'h2;
	localparam int         RESULT_BITS    = 10;

	// Channel codes 01101..01111 and 11000 upward select no source.
	localparam logic [4:0] CHAN_GAP_LO    = 5'h0d;
	localparam logic [4:0] CHAN_GAP_HI    = 5'h0f;
	localparam logic [4:0] CHAN_TOP       = 5'h17;

	typedef enum {
		ST_IDLE,
		ST_RC_WAIT,
		ST_CONVERT,
		ST_RECOVER
	} seq_state_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

endpackage : adc_seq_pkg

// ==== hdl/bit_clock_gen.sv ====
`timescale 1ns/100ps
// ========================================================================
// Bit clock tick generator
// ========================================================================
module bit_clock_gen
	import adc_seq_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic [2:0] div_sel_i,
	input  wire logic       rc_tick_i,
	output logic            tick_o,
	output logic            rc_sel_o
);
	logic [6:0] count_r;
	logic [6:0] count_nxt;
	logic [6:0] ratio;
	logic       div_tick;

	assign rc_sel_o = (div_sel_i[1:0] == DIV_SEL_RC_LOW);
	assign ratio = (div_sel_i == DIV_SEL_8)  ? DIV_RATIO_8 :
	               (div_sel_i == DIV_SEL_16) ? DIV_RATIO_16 :
	               (div_sel_i == DIV_SEL_32) ? DIV_RATIO_32 :
	               (div_sel_i == DIV_SEL_64) ? DIV_RATIO_64 :
	               DIV_RATIO_8;
	assign div_tick  = run_i && (count_r == ratio - 7'h01);
	assign count_nxt = (!run_i || div_tick) ? 7'h00 : count_r + 7'h01;
	assign tick_o    = run_i && (rc_sel_o ? rc_tick_i : div_tick);

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count_r <= 7'h00;
		else
			count_r <= count_nxt;
	end
endmodule : bit_clock_gen

// ==== verification/adc_seq_sva.sv ====
`timescale 1ns/100ps
// ========================================================================
// Port-level checks on the conversion sequencer
// ========================================================================
module adc_seq_sva
	import adc_seq_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic       sleep_i,
	input  wire logic [7:0] rdata_o,
	input  wire logic       powered_o,
	input  wire logic       hold_connect_o,
	input  wire logic [4:0] chan_route_o,
	input  wire logic       chan_valid_o,
	input  wire logic       irq_o,
	input  wire logic       wake_o,
	input  wire logic       vector_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_wake; wake_o == (irq_o && sleep_i); endproperty
	a_wake: assert property (p_wake) else $error("wake mismatch");
	property p_vec; vector_o |-> irq_o; endproperty
	a_vec: assert property (p_vec) else $error("vector without irq");
	property p_rdz; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("stray read data");
	property p_fell; $fell(irq_o) |-> $past(wr_i); endproperty
	a_fell: assert property (p_fell) else $error("irq dropped alone");
	property p_rise; $rose(irq_o) |-> $past(wr_i) || !$past(hold_connect_o);
	endproperty
	a_rise: assert property (p_rise) else $error("irq without cause");
	property p_chp; chan_valid_o |-> powered_o; endproperty
	a_chp: assert property (p_chp) else $error("channel while off");
	property p_chg; chan_valid_o |-> chan_route_o <= CHAN_TOP &&
		!(chan_route_o inside {[CHAN_GAP_LO:CHAN_GAP_HI]}); endproperty
	a_chg: assert property (p_chg) else $error("gap channel valid");
	property p_off; $fell(powered_o) |-> $past(wr_i) || $past(sleep_i);
	endproperty
	a_off: assert property (p_off) else $error("power lost alone");
endmodule : adc_seq_sva

bind adc_conversion_sequencer adc_seq_sva adc_seq_sva_inst (.ref_clk_i,
	.resetn_i, .wr_i, .rd_i, .sleep_i, .rdata_o, .powered_o,
	.hold_connect_o, .chan_route_o, .chan_valid_o, .irq_o, .wake_o,
	.vector_o);

// ==== verification/adc_conversion_sequencer_bench.sv ====
`timescale 1ns/100ps
module adc_conversion_sequencer_bench import adc_seq_pkg::*;;
	logic       ref_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0;
	logic       sleep_i = 0, instr_tick_i = 0, rc_tick_i = 0, comp_i = 0;
	logic [2:0] addr_i = 0;
	logic [7:0] wdata_i = 0, rdata_o, d;
	logic       powered_o, hold_connect_o, chan_valid_o;
	logic       irq_o, wake_o, vector_o;
	logic [4:0] chan_route_o;
	logic [9:0] dac_code_o;
	int         n_errors = 0, n_tests = 0, tc = 0;
	logic [2:0] sels [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
	int         rs [6] = '{8, 16, 32, 64, 20, 20};

	adc_conversion_sequencer adc_conversion_sequencer_inst (.ref_clk_i,
		.resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_i,
		.instr_tick_i, .rc_tick_i, .comp_i, .powered_o, .hold_connect_o,
		.chan_route_o, .chan_valid_o, .dac_code_o, .irq_o, .wake_o,
		.vector_o);

	// ====================================================================
	// Clock, tick sources and bus tasks
	// ====================================================================
	initial forever #2 ref_clk_i = ~ref_clk_i;
	// The RC tick is unrelated to the divider ratios so phases drift.
	always @(posedge ref_clk_i)
	begin
		tc <= tc + 1;
		instr_tick_i <= (tc % 4 == 0);
		rc_tick_i <= (tc % 20 == 7);
	end

	task chk(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk

	task chk_rng(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi)
		begin
			n_errors++;
			$display("wrong value at %0t: %h vs %h", $time, got, lo);
		end
	endtask : chk_rng

	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [2:0] a);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		d = rdata_o;
	endtask : rd

	// Polls the go bit; the span is known only to the poll granularity.
	task convert(input logic [2:0] sel, input int r, input logic s);
		realtime t0;
		wr(ADDR_CTRL_B, {1'b0, sel, 4'h0});
		wr(ADDR_CTRL_A, 8'h01);
		wr(ADDR_CTRL_A, 8'h03);
		t0 = $realtime;
		sleep_i <= s;
		repeat (1000)
		begin
			rd(ADDR_CTRL_A);
			if (d[1] === 1'b0)
				break;
		end
		chk_rng(int'(($realtime - t0) / 4), 10 * r, 12 * r + 12);
	endtask : convert

	task test_done;
		if (n_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// ====================================================================
	// Scenarios
	// ====================================================================
	task reset_regs;
		foreach (sels[i])
		begin
			rd(3'(i));
			chk(d, 0);
		end
		rd(3'h6);
		chk(d, 0);
	endtask : reset_regs

	task dividers;
		wr(ADDR_CTRL_A, 8'h03);
		rd(ADDR_CTRL_A);
		chk(d, 8'h01);
		comp_i <= 1'b1;
		foreach (sels[i])
		begin
			convert(sels[i], rs[i], 1'b0);
			rd(ADDR_RES_HIGH);
			chk(d, 8'h03);
			rd(ADDR_RES_LOW);
			chk(d, 8'hff);
			rd(ADDR_FLAG);
			chk(d, 8'h01);
			chk(irq_o, 0);
			wr(ADDR_FLAG, 8'h00);
		end
	endtask : dividers

	task irq_paths;
		comp_i <= 1'b0;
		convert(DIV_SEL_8, 8, 1'b0);
		rd(ADDR_RES_LOW);
		chk(d, 0);
		wr(ADDR_IRQ_EN, 8'h01);
		chk(irq_o, 1);
		sleep_i <= 1'b1;
		wr(ADDR_IRQ_EN, 8'h01);
		chk({wake_o, vector_o}, 2'b10);
		wr(ADDR_IRQ_EN, 8'h07);
		chk(vector_o, 1);
		sleep_i <= 1'b0;
		wr(ADDR_FLAG, 8'h00);
		chk(irq_o, 0);
		wr(ADDR_IRQ_EN, 8'h00);
	endtask : irq_paths

	task abort_and_sleep;
		comp_i <= 1'b1;
		convert(DIV_SEL_8, 8, 1'b0);
		wr(ADDR_FLAG, 8'h00);
		comp_i <= 1'b0;
		wr(ADDR_CTRL_A, 8'h03);
		repeat (30) @(posedge ref_clk_i);
		chk(hold_connect_o, 0);
		wr(ADDR_CTRL_A, 8'h01);
		rd(ADDR_RES_LOW);
		chk(d, 8'hff);
		rd(ADDR_FLAG);
		chk(d, 0);
		repeat (24) @(posedge ref_clk_i);
		convert(DIV_SEL_8, 8, 1'b0);
		wr(ADDR_CTRL_A, 8'h03);
		sleep_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1;
		chk(powered_o, 0);
		rd(ADDR_CTRL_A);
		chk(d, 8'h01);
		sleep_i <= 1'b0;
		// Let the abort recovery finish before the clock source changes.
		repeat (80) @(posedge ref_clk_i);
		convert(3'h3, 20, 1'b1);
		chk(powered_o, 0);
		sleep_i <= 1'b0;
	endtask : abort_and_sleep

	task chan_reset;
		wr(ADDR_CTRL_A, {1'b0, CHAN_GAP_LO, 2'b01});
		chk(chan_valid_o, 0);
		wr(ADDR_CTRL_A, 8'h41);
		chk({chan_valid_o, chan_route_o}, 6'h30);
		wr(ADDR_CTRL_A, 8'h00);
		chk({powered_o, chan_valid_o}, 0);
		wr(ADDR_CTRL_A, 8'h01);
		repeat (8) @(posedge ref_clk_i);
		wr(ADDR_CTRL_A, 8'h03);
		resetn_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd(ADDR_CTRL_A);
		chk({powered_o, d}, 0);
		chk(dac_code_o, 0);
	endtask : chan_reset

	initial
	begin
		repeat (16) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		reset_regs();
		dividers();
		irq_paths();
		abort_and_sleep();
		chan_reset();
		test_done();
	end

	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		n_errors++;
		test_done();
	end
endmodule : adc_conversion_sequencer_bench
